// ===== hdl/msrsc_top.v
// Purpose: Remote command and query logic for a magnet power supply controller.
// Assumes: Measurement buses come from logic on i_clk; quench and rampdown pins are asynchronous.
// Notes: Commands are register writes; queries are register reads, data one cycle later.
`timescale 1ns/100ps
`default_nettype none
`include "msrsc_map.vh"
module msrsc_top #(
	parameter [31:0] HEAT_CYCLES = `MSRSC_HEAT_TIME_MS * `MSRSC_CLK_KHZ,
	parameter [31:0] COOL_CYCLES = `MSRSC_COOL_TIME_MS * `MSRSC_CLK_KHZ
) (
	// Clock and reset.
	input wire i_clk,
	input wire i_nrst,
	// Register port.
	input wire [7:0] i_addr,
	input wire [31:0] i_wdata,
	input wire i_wr,
	input wire i_rd,
	output reg [31:0] o_rdata,
	// Measurements.
	input wire [31:0] i_magnet_volt,
	input wire [31:0] i_magnet_curr,
	input wire [31:0] i_supply_curr,
	// Asynchronous pins.
	input wire i_quench_detect,
	input wire i_ext_rampdown,
	input wire i_unipolar,
	// Supply and panel outputs.
	output reg [31:0] o_supply_volt_cmd,
	output reg [31:0] o_ref_curr,
	output reg o_quench_out,
	output reg o_switch_heater,
	output reg o_persist_led,
	output reg o_null_reached_status,
	output reg [10:0] o_state_lamps
);
	// Moves cur toward goal by at most step; cur and goal signed, step unsigned.
	function [31:0] step_toward;
		input [31:0] cur;
		input [31:0] goal;
		input [31:0] step;
		reg signed [32:0] diff;
		begin
			diff = $signed({goal[31], goal}) - $signed({cur[31], cur});
			if (diff > $signed({1'b0, step})) begin
				step_toward = cur + step;
			end else if (diff < -$signed({1'b0, step})) begin
				step_toward = cur - step;
			end else begin
				step_toward = goal;
			end
		end
	endfunction
	// Fixed-point product of a current and the 16.16 coil constant.
	function [31:0] to_field;
		input [31:0] curr;
		input [31:0] coil;
		reg signed [63:0] prod;
		begin
			prod = $signed(curr) * $signed(coil);
			to_field = prod[`MSRSC_COIL_FRAC +: 32];
		end
	endfunction
	function [31:0] abs32;
		input [31:0] v;
		begin
			abs32 = v[31] ? (32'h0 - v) : v;
		end
	endfunction

	reg qd_s1_q, qd_s2_q, er_s1_q, er_s2_q, un_s1_q, un_s2_q;
	reg [3:0] state_q, state_d;
	reg [31:0] ref_q, ref_d;
	reg [31:0] coil_q, target_q, limit_q, rate_q, imax_q;
	reg coil_def_q, ferr_q, quench_q, heater_q, persist_q;
	reg [31:0] latch_curr_q, latch_field_q;
	reg [31:0] timer_q;
	reg [7:0] qcount_q;
	reg bank_q, backup_valid_q;
	reg [31:0] log_mem [0:199];
	reg qd_prev_q;

	wire wr_cmd = i_wr && (i_addr == `MSRSC_REG_CMD);
	wire [3:0] op = i_wdata[`MSRSC_OP_MSB:0];
	wire arg = i_wdata[`MSRSC_ARG_BIT];
	wire quench_rise = qd_s2_q && !qd_prev_q;
	wire quench_cmd = wr_cmd && (op == `MSRSC_OP_QUENCH) && arg;
	wire quench_clr = wr_cmd && (op == `MSRSC_OP_QUENCH) && !arg;
	wire quench_event = (quench_rise || quench_cmd) && !quench_q;
	wire heater_cmd = wr_cmd && (op == `MSRSC_OP_HEATER);
	wire [31:0] zero_thresh = imax_q / `MSRSC_ZERO_DIV;
	wire unipolar_s = un_s2_q;
	wire [31:0] neg_limit = unipolar_s ? 32'h0 : (32'h0 - limit_q);
	wire field_rd = i_rd && ((i_addr == `MSRSC_REG_FIELD) || (i_addr == `MSRSC_REG_FIELD_REF));
	wire [7:0] dump_addr;
	wire [7:0] dump_char;
	wire dump_active;
	wire dump_pop = i_rd && (i_addr == `MSRSC_REG_DUMP);
	wire dump_start = wr_cmd && ((op == `MSRSC_OP_DUMP_FILE) || (op == `MSRSC_OP_DUMP_BACKUP));
	wire dump_bk = (op == `MSRSC_OP_DUMP_BACKUP);
	wire [7:0] cur_base = bank_q ? `MSRSC_LOG_DEPTH : 8'h00;
	wire [7:0] bk_base = bank_q ? 8'h00 : `MSRSC_LOG_DEPTH;
	wire [7:0] bk_count = backup_valid_q ? `MSRSC_LOG_DEPTH : 8'h00;
	wire [31:0] mag_curr_view = persist_q ? latch_curr_q : i_magnet_curr;
	wire [31:0] field_view = persist_q ? latch_field_q : to_field(i_magnet_curr, coil_q);
	wire [31:0] field_ref_view = persist_q ? latch_field_q : to_field(ref_q, coil_q);

	msrsc_dump_seq u_dump (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_start(dump_start),
		.i_base(dump_bk ? bk_base : cur_base),
		.i_count(dump_bk ? bk_count : qcount_q),
		.i_pop(dump_pop),
		.o_addr(dump_addr),
		.i_word(log_mem[dump_addr]),
		.o_char(dump_char),
		.o_active(dump_active)
	);

	// Pin synchronisers.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			qd_s1_q <= 1'b0;
			qd_s2_q <= 1'b0;
			er_s1_q <= 1'b0;
			er_s2_q <= 1'b0;
			un_s1_q <= 1'b0;
			un_s2_q <= 1'b0;
			qd_prev_q <= 1'b0;
		end else begin
			qd_s1_q <= i_quench_detect;
			qd_s2_q <= qd_s1_q;
			er_s1_q <= i_ext_rampdown;
			er_s2_q <= er_s1_q;
			un_s1_q <= i_unipolar;
			un_s2_q <= un_s1_q;
			qd_prev_q <= qd_s2_q;
		end
	end

	// Ramping state machine and reference.
	always @* begin
		state_d = state_q;
		ref_d = ref_q;
		if (wr_cmd && !quench_q) begin
			case (op)
				`MSRSC_OP_RAMP: state_d = `MSRSC_ST_RAMPING;
				`MSRSC_OP_PAUSE: state_d = `MSRSC_ST_PAUSED;
				`MSRSC_OP_UP: state_d = `MSRSC_ST_MAN_UP;
				`MSRSC_OP_DOWN: state_d = `MSRSC_ST_MAN_DOWN;
				`MSRSC_OP_ZERO: state_d = `MSRSC_ST_ZEROING;
				`MSRSC_OP_HEATER: state_d = arg ? `MSRSC_ST_HEATING : `MSRSC_ST_COOLING;
				default: state_d = state_q;
			endcase
		end
		case (state_q)
			`MSRSC_ST_RAMPING: begin
				ref_d = step_toward(ref_q, target_q, rate_q);
				if (ref_d == target_q) begin
					state_d = (state_d == state_q) ? `MSRSC_ST_HOLDING : state_d;
				end
			end
			`MSRSC_ST_MAN_UP: ref_d = step_toward(ref_q, limit_q, rate_q);
			`MSRSC_ST_MAN_DOWN: ref_d = step_toward(ref_q, neg_limit, rate_q);
			`MSRSC_ST_ZEROING: begin
				ref_d = step_toward(ref_q, 32'h0, rate_q);
				if ((abs32(i_supply_curr) < zero_thresh) && (state_d == state_q)) begin
					state_d = `MSRSC_ST_NULL_REACHED_STATUS;
				end
			end
			`MSRSC_ST_EXT_DOWN: begin
				ref_d = step_toward(ref_q, 32'h0, rate_q);
				if (!er_s2_q) begin
					state_d = `MSRSC_ST_PAUSED;
				end
			end
			`MSRSC_ST_HEATING: begin
				if ((timer_q == 32'h0) && (state_d == state_q)) begin
					state_d = `MSRSC_ST_PAUSED;
				end
			end
			`MSRSC_ST_COOLING: begin
				if ((timer_q == 32'h0) && (state_d == state_q)) begin
					state_d = `MSRSC_ST_PAUSED;
				end
			end
			`MSRSC_ST_QUENCH: begin
				if (quench_clr) begin
					state_d = `MSRSC_ST_PAUSED;
				end
			end
			default: ref_d = ref_q;
		endcase
		if (er_s2_q && !quench_q && (state_d != `MSRSC_ST_EXT_DOWN) && (state_q != `MSRSC_ST_EXT_DOWN)) begin
			state_d = `MSRSC_ST_EXT_DOWN;
		end
		if (quench_event || (quench_q && !quench_clr)) begin
			state_d = `MSRSC_ST_QUENCH;
			ref_d = 32'h0;
		end
	end

	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			state_q <= `MSRSC_ST_PAUSED;
			ref_q <= 32'h0;
			timer_q <= 32'h0;
			heater_q <= 1'b0;
			persist_q <= 1'b0;
			latch_curr_q <= 32'h0;
			latch_field_q <= 32'h0;
			quench_q <= 1'b0;
		end else begin
			state_q <= state_d;
			ref_q <= ref_d;
			if (heater_cmd && !quench_q) begin
				heater_q <= arg;
				timer_q <= arg ? HEAT_CYCLES : COOL_CYCLES;
				if (arg) begin
					persist_q <= 1'b0;
				end
			end else if (timer_q != 32'h0) begin
				timer_q <= timer_q - 32'h1;
			end
			// Persistent mode begins when the switch has cooled; values are latched then.
			if ((state_q == `MSRSC_ST_COOLING) && (timer_q == 32'h0) && !heater_q && !persist_q) begin
				persist_q <= 1'b1;
				latch_curr_q <= i_magnet_curr;
				latch_field_q <= to_field(i_magnet_curr, coil_q);
			end
			// A new quench wins over a clear in the same cycle.
			if (quench_event) begin
				quench_q <= 1'b1;
			end else if (quench_clr) begin
				quench_q <= 1'b0;
			end
		end
	end

	// Quench log with rollover to the backup bank.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			qcount_q <= 8'h00;
			bank_q <= 1'b0;
			backup_valid_q <= 1'b0;
		end else if (quench_event) begin
			if (qcount_q == `MSRSC_LOG_DEPTH - 8'd1) begin
				qcount_q <= 8'h00;
				bank_q <= !bank_q;
				backup_valid_q <= 1'b1;
			end else begin
				qcount_q <= qcount_q + 8'h01;
			end
		end
	end
	always @(posedge i_clk) begin
		if (quench_event) begin
			log_mem[cur_base + qcount_q] <= i_magnet_curr;
		end
	end

	// Configuration registers.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			coil_q <= 32'h0;
			coil_def_q <= 1'b0;
			target_q <= 32'h0;
			limit_q <= 32'h0;
			rate_q <= 32'h0;
			imax_q <= 32'h0;
			ferr_q <= 1'b0;
		end else begin
			if (i_wr) begin
				case (i_addr)
					`MSRSC_REG_COIL: begin
						coil_q <= i_wdata;
						coil_def_q <= (i_wdata != 32'h0);
					end
					`MSRSC_REG_TARGET: target_q <= i_wdata;
					`MSRSC_REG_LIMIT: limit_q <= i_wdata;
					`MSRSC_REG_RATE: rate_q <= i_wdata;
					`MSRSC_REG_IMAX: imax_q <= i_wdata;
					default: coil_q <= coil_q;
				endcase
			end
			// Error set by a field read wins over a clear written in the same cycle.
			if (field_rd && !coil_def_q) begin
				ferr_q <= 1'b1;
			end else if (i_wr && (i_addr == `MSRSC_REG_STATUS) && i_wdata[`MSRSC_STS_FERR]) begin
				ferr_q <= 1'b0;
			end
		end
	end

	// Read data, valid only in the cycle after the strobe.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata <= 32'h0;
		end else if (!i_rd) begin
			o_rdata <= 32'h0;
		end else begin
			case (i_addr)
				`MSRSC_REG_STATE: o_rdata <= {28'h0, state_q};
				`MSRSC_REG_STATUS: o_rdata <= {25'h0, dump_active, ferr_q, coil_def_q,
					o_null_reached_status, quench_q, persist_q, heater_q};
				`MSRSC_REG_MAG_VOLT: o_rdata <= i_magnet_volt;
				`MSRSC_REG_SUP_VOLT: o_rdata <= o_supply_volt_cmd;
				`MSRSC_REG_MAG_CURR: o_rdata <= mag_curr_view;
				`MSRSC_REG_SUP_CURR: o_rdata <= i_supply_curr;
				`MSRSC_REG_REF_CURR: o_rdata <= ref_q;
				`MSRSC_REG_FIELD: o_rdata <= coil_def_q ? field_view : 32'h0;
				`MSRSC_REG_FIELD_REF: o_rdata <= coil_def_q ? field_ref_view : 32'h0;
				`MSRSC_REG_QCOUNT: o_rdata <= {24'h0, qcount_q};
				`MSRSC_REG_COIL: o_rdata <= coil_q;
				`MSRSC_REG_TARGET: o_rdata <= target_q;
				`MSRSC_REG_LIMIT: o_rdata <= limit_q;
				`MSRSC_REG_RATE: o_rdata <= rate_q;
				`MSRSC_REG_IMAX: o_rdata <= imax_q;
				`MSRSC_REG_DUMP: o_rdata <= {23'h0, dump_active, dump_active ? dump_char : 8'h00};
				default: o_rdata <= 32'h0;
			endcase
		end
	end

	// Supply and panel outputs.
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_supply_volt_cmd <= 32'h0;
			o_ref_curr <= 32'h0;
			o_quench_out <= 1'b0;
			o_switch_heater <= 1'b0;
			o_persist_led <= 1'b0;
			o_null_reached_status <= 1'b0;
			o_state_lamps <= 11'h0;
		end else begin
			// The commanded voltage is the drive error; a quench forces it to zero.
			o_supply_volt_cmd <= quench_q ? 32'h0 : (ref_q - i_supply_curr);
			o_ref_curr <= ref_q;
			o_quench_out <= quench_q;
			o_switch_heater <= heater_q;
			o_persist_led <= persist_q;
			o_null_reached_status <= (state_q == `MSRSC_ST_NULL_REACHED_STATUS);
			o_state_lamps <= 11'h1 << (state_q - 4'h1);
		end
	end
endmodule
`default_nettype wire

// ===== include/msrsc_map.vh
// Purpose: Constants for the magnet supply remote state command block.
// Assumes: Registers are 32-bit words at byte offsets on a plain strobe port.
// Notes: Included by bare name from every design file.
`ifndef MSRSC_MAP_VH
`define MSRSC_MAP_VH
// Register byte offsets.
`define MSRSC_REG_CMD 8'h00
`define MSRSC_REG_STATE 8'h04
`define MSRSC_REG_STATUS 8'h08
`define MSRSC_REG_MAG_VOLT 8'h0c
`define MSRSC_REG_SUP_VOLT 8'h10
`define MSRSC_REG_MAG_CURR 8'h14
`define MSRSC_REG_SUP_CURR 8'h18
`define MSRSC_REG_REF_CURR 8'h1c
`define MSRSC_REG_FIELD 8'h20
`define MSRSC_REG_FIELD_REF 8'h24
`define MSRSC_REG_QCOUNT 8'h28
`define MSRSC_REG_COIL 8'h2c
`define MSRSC_REG_TARGET 8'h30
`define MSRSC_REG_LIMIT 8'h34
`define MSRSC_REG_RATE 8'h38
`define MSRSC_REG_IMAX 8'h3c
`define MSRSC_REG_DUMP 8'h40
// Command word fields.
`define MSRSC_OP_MSB 3
`define MSRSC_ARG_BIT 4
// Command opcodes.
`define MSRSC_OP_RAMP 4'h1
`define MSRSC_OP_PAUSE 4'h2
`define MSRSC_OP_UP 4'h3
`define MSRSC_OP_DOWN 4'h4
`define MSRSC_OP_ZERO 4'h5
`define MSRSC_OP_HEATER 4'h6
`define MSRSC_OP_QUENCH 4'h7
`define MSRSC_OP_DUMP_FILE 4'h8
`define MSRSC_OP_DUMP_BACKUP 4'h9
// Ramping state codes as returned by the state query.
`define MSRSC_ST_RAMPING 4'h1
`define MSRSC_ST_HOLDING 4'h2
`define MSRSC_ST_PAUSED 4'h3
`define MSRSC_ST_MAN_UP 4'h4
`define MSRSC_ST_MAN_DOWN 4'h5
`define MSRSC_ST_ZEROING 4'h6
`define MSRSC_ST_QUENCH 4'h7
`define MSRSC_ST_NULL_REACHED_STATUS 4'h8
`define MSRSC_ST_HEATING 4'h9
`define MSRSC_ST_COOLING 4'ha
`define MSRSC_ST_EXT_DOWN 4'hb
// Status register bit positions.
`define MSRSC_STS_HEATER 0
`define MSRSC_STS_PERSIST 1
`define MSRSC_STS_QUENCH 2
`define MSRSC_STS_NULL 3
`define MSRSC_STS_COIL 4
`define MSRSC_STS_FERR 5
`define MSRSC_STS_DUMP 6
`define MSRSC_STS_WIDTH 7
// Dump data register: valid flag above the character.
`define MSRSC_DUMP_VALID 8
// Quench log size and the zero threshold divisor (0.1 percent).
`define MSRSC_LOG_DEPTH 8'd100
`define MSRSC_ZERO_DIV 32'd1000
// Coil constant is 16.16 fixed point.
`define MSRSC_COIL_FRAC 16
// Switch heating and cooling times in milliseconds, clock in kHz.
`define MSRSC_HEAT_TIME_MS 20
`define MSRSC_COOL_TIME_MS 20
`define MSRSC_CLK_KHZ 200000
// Dump characters.
`define MSRSC_CHR_CR 8'h0d
`define MSRSC_CHR_LF 8'h0a
`define MSRSC_HEX_DIGITS 4'h8
`define MSRSC_POS_CR 4'h8
`define MSRSC_POS_LF 4'h9
`endif

// ===== hdl/msrsc_dump_seq.v
// Purpose: Streams quench log entries as hex text lines, one character per pop.
// Assumes: The log word at o_addr is presented combinationally on i_word.
// Notes: Each entry is eight hex digits and CR LF; the stream ends with CR LF CR LF.
`timescale 1ns/100ps
`default_nettype none
`include "msrsc_map.vh"
module msrsc_dump_seq (
	// Clock and reset.
	input wire i_clk,
	input wire i_nrst,
	// Control.
	input wire i_start,
	input wire [7:0] i_base,
	input wire [7:0] i_count,
	input wire i_pop,
	// Log memory.
	output wire [7:0] o_addr,
	input wire [31:0] i_word,
	// Character out.
	output reg [7:0] o_char,
	output wire o_active
);
	reg active_q;
	reg [7:0] idx_q;
	reg [7:0] base_q;
	reg [7:0] count_q;
	reg [3:0] pos_q;
	reg [1:0] tail_q;
	wire in_tail = (idx_q == count_q);
	wire [3:0] nib = i_word[(4'h7 - pos_q[2:0]) * 4 +: 4];
	assign o_addr = base_q + idx_q;
	assign o_active = active_q;
	always @* begin
		if (in_tail) begin
			o_char = tail_q[0] ? `MSRSC_CHR_LF : `MSRSC_CHR_CR;
		end else if (pos_q == `MSRSC_POS_CR) begin
			o_char = `MSRSC_CHR_CR;
		end else if (pos_q == `MSRSC_POS_LF) begin
			o_char = `MSRSC_CHR_LF;
		end else if (nib < 4'ha) begin
			o_char = {4'h3, nib};
		end else begin
			o_char = 8'h57 + {4'h0, nib};
		end
	end
	always @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			active_q <= 1'b0;
			idx_q <= 8'h00;
			base_q <= 8'h00;
			count_q <= 8'h00;
			pos_q <= 4'h0;
			tail_q <= 2'h0;
		end else if (i_start) begin
			active_q <= 1'b1;
			idx_q <= 8'h00;
			base_q <= i_base;
			count_q <= i_count;
			pos_q <= 4'h0;
			// An empty log still ends with two CR LF pairs.
			tail_q <= (i_count == 8'h00) ? 2'h0 : 2'h2;
		end else if (i_pop && active_q) begin
			if (in_tail) begin
				tail_q <= tail_q + 2'h1;
				if (tail_q == 2'h3) begin
					active_q <= 1'b0;
				end
			end else if (pos_q == `MSRSC_POS_LF) begin
				pos_q <= 4'h0;
				idx_q <= idx_q + 8'h01;
			end else begin
				pos_q <= pos_q + 4'h1;
			end
		end
	end
endmodule
`default_nettype wire

// ===== verif/msrsc_sva.sv
// Purpose: Concurrent checks on the ports of the remote state command block.
// Assumes: One clock domain; reset is asynchronous and active low.
// Notes: Attached to every instance of the top module by the bind below.
`timescale 1ns/100ps
`default_nettype none
`include "msrsc_map.vh"
module msrsc_sva #(
	parameter [31:0] HEAT_CYCLES = 32'h8,
	parameter [31:0] COOL_CYCLES = 32'h8
) (
	// Clock, reset and register port.
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_addr,
	input wire logic [31:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [31:0] o_rdata,
	// Measurements and pins.
	input wire logic [31:0] i_magnet_volt,
	input wire logic [31:0] i_supply_curr,
	input wire logic i_quench_detect,
	// Supply and panel outputs.
	input wire logic [31:0] o_supply_volt_cmd,
	input wire logic [31:0] o_ref_curr,
	input wire logic o_quench_out,
	input wire logic o_switch_heater,
	input wire logic o_persist_led,
	input wire logic o_null_reached_status,
	input wire logic [10:0] o_state_lamps
);
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	chk_mag_volt_read: assert property (
		$past(i_rd) && $past(i_addr) == `MSRSC_REG_MAG_VOLT |-> o_rdata == $past(i_magnet_volt))
		else $error("magnet voltage read differs from tap input");
	chk_sup_curr_read: assert property (
		$past(i_rd) && $past(i_addr) == `MSRSC_REG_SUP_CURR |-> o_rdata == $past(i_supply_curr))
		else $error("supply current read differs from measurement");
	chk_ref_read: assert property (
		$past(i_rd) && $past(i_addr) == `MSRSC_REG_REF_CURR && $stable(o_ref_curr) |-> o_rdata == o_ref_curr)
		else $error("reference read differs from reference output");
	chk_quench_output_zero: assert property (
		o_quench_out && $past(o_quench_out) |-> o_supply_volt_cmd == 32'h0 && o_ref_curr == 32'h0)
		else $error("supply not forced to zero during quench");
	chk_quench_lamp_shown: assert property (
		o_quench_out && $past(o_quench_out) |-> o_state_lamps == 11'h040)
		else $error("quench state lamp not shown");
	chk_quench_pin_seen: assert property (
		$rose(i_quench_detect) && !o_quench_out |-> ##[1:5] o_quench_out)
		else $error("quench pin not acted on");
	chk_pause_lamp_cmd: assert property (
		$past(i_wr) && $past(i_addr) == `MSRSC_REG_CMD && $past(i_wdata[3:0]) == `MSRSC_OP_PAUSE
		&& !$past(o_quench_out) |-> ##[1:2] o_state_lamps == 11'h004)
		else $error("pause command not shown on lamps");
	chk_null_lamp_shown: assert property (
		$rose(o_null_reached_status) |-> ##[0:1] o_state_lamps == 11'h080)
		else $error("null_reached_status status without null_reached_status lamp");
	chk_persist_heater_off: assert property (
		o_persist_led && $past(o_persist_led) |-> !$past(o_switch_heater))
		else $error("persistent indicator lit with heater on");
endmodule
bind msrsc_top msrsc_sva #(.HEAT_CYCLES(HEAT_CYCLES), .COOL_CYCLES(COOL_CYCLES)) u_sva (
	.i_clk(i_clk), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
	.o_rdata(o_rdata), .i_magnet_volt(i_magnet_volt), .i_supply_curr(i_supply_curr),
	.i_quench_detect(i_quench_detect), .o_supply_volt_cmd(o_supply_volt_cmd), .o_ref_curr(o_ref_curr),
	.o_quench_out(o_quench_out), .o_switch_heater(o_switch_heater), .o_persist_led(o_persist_led),
	.o_null_reached_status(o_null_reached_status), .o_state_lamps(o_state_lamps));
`default_nettype wire

// ===== verif/msrsc_host.sv
// Purpose: Remote host model issuing commands and queries on the register port.
// Assumes: Strobes one cycle long, read data stands one cycle after the read.
// Notes: Address and data show inverted values while no strobe is high.
`timescale 1ns/100ps
`default_nettype none
`include "msrsc_map.vh"
module msrsc_host (
	// Clock and read data.
	input wire logic i_clk,
	input wire logic [31:0] i_rdata,
	// Request side.
	output var logic [7:0] o_addr,
	output var logic [31:0] o_wdata,
	output var logic o_wr,
	output var logic o_rd
);
	logic [7:0] txt[$];
	initial begin
		o_addr = 8'h0;
		o_wdata = 32'h0;
		o_wr = 1'b0;
		o_rd = 1'b0;
	end
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clk);
		o_wr <= 1'b1;
		o_addr <= a;
		o_wdata <= d;
		@(posedge i_clk);
		o_wr <= 1'b0;
		o_addr <= ~a;
		o_wdata <= ~d;
	endtask
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge i_clk);
		o_rd <= 1'b1;
		o_addr <= a;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_addr <= ~a;
		#1 d = i_rdata;
	endtask
	// The whole reply is kept, since a log dump runs to over a thousand characters.
	task dump(input logic [31:0] op);
		logic [31:0] d;
		txt = {};
		wr(`MSRSC_REG_CMD, op);
		repeat (1100) begin
			rd(`MSRSC_REG_DUMP, d);
			if (d[`MSRSC_DUMP_VALID] !== 1'b1) break;
			txt.push_back(d[7:0]);
		end
	endtask
endmodule
`default_nettype wire

// ===== verif/msrsc_test.sv
// Purpose: Self-checking bench for the remote state command block.
// Assumes: Switch heating and cooling shortened to 8 cycles.
// Notes: Scenarios run in order; each leaves the block in a known state.
`timescale 1ns/100ps
`default_nettype none
`include "msrsc_map.vh"
module msrsc_test;
	logic i_clk, i_nrst, wr, rd, qd, erd, uni, qo, sh, pl, nz;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, mv, mc, sc, svc, refc;
	logic [10:0] lamps;
	int mismatches = 0;
	int checks_done = 0;
	msrsc_top #(.HEAT_CYCLES(32'h8), .COOL_CYCLES(32'h8)) DUT (.i_clk(i_clk), .i_nrst(i_nrst),
		.i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_magnet_volt(mv),
		.i_magnet_curr(mc), .i_supply_curr(sc), .i_quench_detect(qd), .i_ext_rampdown(erd),
		.i_unipolar(uni), .o_supply_volt_cmd(svc), .o_ref_curr(refc), .o_quench_out(qo),
		.o_switch_heater(sh), .o_persist_led(pl), .o_null_reached_status(nz), .o_state_lamps(lamps));
	msrsc_host u_host (.i_clk(i_clk), .i_rdata(rdata), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	task chk(input logic [31:0] g, e);
		checks_done++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task close_out;
		$display("checks=%0d mismatches=%0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		u_host.rd(a, d);
		chk(d, e);
	endtask
	task rds(input int b, input logic e);
		logic [31:0] d;
		u_host.rd(`MSRSC_REG_STATUS, d);
		chk(d[b], e);
	endtask
	// Polls a register a bounded number of times, then compares.
	task poll(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		for (int i = 0; i < 300; i++) begin
			u_host.rd(a, d);
			if (d === e) break;
		end
		chk(d, e);
	endtask
	task cmd(input logic [31:0] c);
		u_host.wr(`MSRSC_REG_CMD, c);
	endtask
	task t_reset;
		chk(lamps, 11'h004);
		chk({qo, sh, pl, nz}, 4'h0);
		rdc(`MSRSC_REG_STATE, 32'h3);
		rds(`MSRSC_STS_HEATER, 1'b0);
		rdc(8'h7c, 32'h0);
	endtask
	task t_meas;
		@(posedge i_clk);
		mv <= 32'h0000_1234;
		sc <= 32'h5;
		mc <= 32'h5;
		rdc(`MSRSC_REG_MAG_VOLT, 32'h0000_1234);
		rdc(`MSRSC_REG_SUP_CURR, 32'h5);
		rdc(`MSRSC_REG_MAG_CURR, 32'h5);
		rdc(`MSRSC_REG_SUP_VOLT, 32'hffff_fffb);
	endtask
	task t_field;
		rdc(`MSRSC_REG_FIELD, 32'h0);
		rds(`MSRSC_STS_FERR, 1'b1);
		u_host.wr(`MSRSC_REG_STATUS, 32'h20);
		rds(`MSRSC_STS_FERR, 1'b0);
		u_host.wr(`MSRSC_REG_COIL, 32'h0002_0000);
		rdc(`MSRSC_REG_FIELD, 32'ha);
	endtask
	task t_ramp;
		logic [31:0] r;
		u_host.wr(`MSRSC_REG_RATE, 32'h4);
		u_host.wr(`MSRSC_REG_TARGET, 32'h28);
		cmd({28'h0, `MSRSC_OP_RAMP});
		rdc(`MSRSC_REG_STATE, 32'h1);
		poll(`MSRSC_REG_STATE, 32'h2);
		rdc(`MSRSC_REG_REF_CURR, 32'h28);
		chk(refc, 32'h28);
		rdc(`MSRSC_REG_FIELD_REF, 32'h50);
		u_host.wr(`MSRSC_REG_TARGET, 32'h190);
		cmd({28'h0, `MSRSC_OP_RAMP});
		repeat (4) @(posedge i_clk);
		cmd({28'h0, `MSRSC_OP_PAUSE});
		u_host.rd(`MSRSC_REG_REF_CURR, r);
		repeat (10) @(posedge i_clk);
		rdc(`MSRSC_REG_REF_CURR, r);
		chk(r < 32'h190 && r > 32'h28, 1'b1);
		rdc(`MSRSC_REG_STATE, 32'h3);
	endtask
	task t_manual;
		u_host.wr(`MSRSC_REG_LIMIT, 32'h3c);
		cmd({28'h0, `MSRSC_OP_UP});
		rdc(`MSRSC_REG_STATE, 32'h4);
		poll(`MSRSC_REG_REF_CURR, 32'h3c);
		@(posedge i_clk);
		uni <= 1'b1;
		cmd({28'h0, `MSRSC_OP_DOWN});
		rdc(`MSRSC_REG_STATE, 32'h5);
		poll(`MSRSC_REG_REF_CURR, 32'h0);
		@(posedge i_clk);
		uni <= 1'b0;
		repeat (4) @(posedge i_clk);
		cmd({28'h0, `MSRSC_OP_DOWN});
		poll(`MSRSC_REG_REF_CURR, 32'hffff_ffc4);
	endtask
	task t_zero;
		u_host.wr(`MSRSC_REG_IMAX, 32'h3e8);
		cmd({28'h0, `MSRSC_OP_ZERO});
		rdc(`MSRSC_REG_STATE, 32'h6);
		@(posedge i_clk);
		sc <= 32'h0;
		poll(`MSRSC_REG_STATE, 32'h8);
		repeat (2) @(posedge i_clk);
		chk(nz, 1'b1);
		rds(`MSRSC_STS_NULL, 1'b1);
	endtask
	task t_heater;
		cmd(32'h16);
		rdc(`MSRSC_REG_STATE, 32'h9);
		rds(`MSRSC_STS_HEATER, 1'b1);
		chk(sh, 1'b1);
		poll(`MSRSC_REG_STATE, 32'h3);
		cmd(32'h06);
		rdc(`MSRSC_REG_STATE, 32'ha);
		poll(`MSRSC_REG_STATE, 32'h3);
		rds(`MSRSC_STS_PERSIST, 1'b1);
		chk(pl, 1'b1);
		@(posedge i_clk);
		mc <= 32'h7;
		rdc(`MSRSC_REG_MAG_CURR, 32'h5);
		rdc(`MSRSC_REG_FIELD, 32'ha);
		cmd(32'h16);
		poll(`MSRSC_REG_STATE, 32'h3);
		rds(`MSRSC_STS_PERSIST, 1'b0);
		chk(pl, 1'b0);
	endtask
	task t_extdown;
		@(posedge i_clk);
		erd <= 1'b1;
		poll(`MSRSC_REG_STATE, 32'hb);
		@(posedge i_clk);
		erd <= 1'b0;
		poll(`MSRSC_REG_STATE, 32'h3);
	endtask
	task t_quench;
		@(posedge i_clk);
		mc <= 32'h0000_abcd;
		cmd(32'h17);
		rdc(`MSRSC_REG_STATE, 32'h7);
		rds(`MSRSC_STS_QUENCH, 1'b1);
		chk(qo, 1'b1);
		chk(svc, 32'h0);
		cmd({28'h0, `MSRSC_OP_RAMP});
		rdc(`MSRSC_REG_STATE, 32'h7);
		rdc(`MSRSC_REG_QCOUNT, 32'h1);
		cmd(32'h07);
		rdc(`MSRSC_REG_STATE, 32'h3);
		rds(`MSRSC_STS_QUENCH, 1'b0);
		@(posedge i_clk);
		qd <= 1'b1;
		repeat (6) @(posedge i_clk);
		chk(qo, 1'b1);
		qd <= 1'b0;
		rdc(`MSRSC_REG_QCOUNT, 32'h2);
		cmd(32'h07);
	endtask
	task t_log;
		string e;
		int n;
		e = "0000abcd";
		for (int i = 0; i < 98; i++) begin
			cmd(32'h17);
			cmd(32'h07);
		end
		rdc(`MSRSC_REG_QCOUNT, 32'h0);
		u_host.dump({28'h0, `MSRSC_OP_DUMP_FILE});
		chk(u_host.txt.size(), 32'h4);
		chk({u_host.txt[0], u_host.txt[1], u_host.txt[2], u_host.txt[3]}, 32'h0d0a0d0a);
		u_host.dump({28'h0, `MSRSC_OP_DUMP_BACKUP});
		n = u_host.txt.size();
		chk(n, 32'd1002);
		chk({u_host.txt[n-4], u_host.txt[n-3], u_host.txt[n-2], u_host.txt[n-1]}, 32'h0d0a0d0a);
		for (int i = 0; i < 8; i++) chk(u_host.txt[i], e[i]);
		chk({u_host.txt[8], u_host.txt[9]}, 16'h0d0a);
	endtask
	initial begin
		repeat (60000) @(posedge i_clk);
		mismatches++;
		close_out();
	end
	initial begin
		i_nrst = 1'b0;
		{qd, erd, uni} = 3'h0;
		{mv, mc, sc} = 96'h0;
		repeat (10) @(posedge i_clk);
		i_nrst <= 1'b1;
		repeat (2) @(posedge i_clk);
		t_reset();
		t_meas();
		t_field();
		t_ramp();
		t_manual();
		t_zero();
		t_heater();
		t_extdown();
		t_quench();
		t_log();
		close_out();
	end
endmodule
`default_nettype wire
